// File: include/sbp_pkg.sv
// Package of register map, field layout and timing constants for the port
package sbp_pkg;
  // Register offsets (index in words on the plain register port)
  localparam logic [7:0] ADDR_RX_UPPER   = 8'h00;
  localparam logic [7:0] ADDR_RX_LOWER   = 8'h01;
  localparam logic [7:0] ADDR_TX_UPPER   = 8'h02;
  localparam logic [7:0] ADDR_TX_LOWER   = 8'h03;
  localparam logic [7:0] ADDR_PORT_CTL1  = 8'h04;
  localparam logic [7:0] ADDR_PORT_CTL2  = 8'h05;
  localparam logic [7:0] ADDR_PIN_CTL    = 8'h06;
  localparam logic [7:0] ADDR_RX_CTL     = 8'h07;
  localparam logic [7:0] ADDR_TX_CTL     = 8'h08;
  localparam logic [7:0] ADDR_MCH_CTL    = 8'h09;
  localparam logic [7:0] ADDR_RX_CHEN    = 8'h0A;
  localparam logic [7:0] ADDR_TX_CHEN    = 8'h0B;
  localparam logic [7:0] ADDR_TXQ_CTL    = 8'h20;
  localparam logic [7:0] ADDR_RXQ_CTL    = 8'h21;
  localparam logic [7:0] ADDR_Q_GEN      = 8'h22;
  localparam logic [7:0] ADDR_Q_INT      = 8'h23;
  localparam logic [7:0] ADDR_Q_STAT     = 8'h24;
  // Reset values
  localparam logic [15:0] RST_ZERO       = 16'h0000;
  localparam logic [15:0] RST_TXQ_CTL    = 16'hA000;
  localparam logic [15:0] RST_RXQ_CTL    = 16'h201F;
  // Field positions
  localparam int BIT_RX_RESET_N   = 0;  // port_control_one
  localparam int BIT_TX_RESET_N   = 0;  // port_control_two
  localparam int BIT_FS_RESET_N   = 7;  // port_control_two
  localparam int BIT_RATE_RESET_N = 6;  // port_control_two
  localparam int BIT_Q_ENABLE     = 14; // tx_queue_control
  localparam int BIT_Q_TX_RESET   = 13; // tx_queue_control, 1 = run
  localparam int BIT_Q_RX_RESET   = 13; // rx_queue_control, 1 = run
  localparam int BIT_PIN_RSV_LO   = 12;
  localparam int BIT_PIN_RSV_HI   = 13;
  localparam int BIT_FS_IGNORE    = 15; // control: frame_sync_ignore
  localparam int BIT_PHASE        = 14; // control: phase select
  localparam int LSB_FRLEN        = 7;  // phase1_frame_length, 7 bits
  localparam int LSB_WDLEN        = 4;  // phase1_word_length, 3 bits
  localparam int LSB_QCOUNT       = 8;  // level field in queue control
  // Word length codes
  localparam logic [2:0] WDLEN_8  = 3'h0;
  localparam logic [2:0] WDLEN_12 = 3'h1;
  localparam logic [2:0] WDLEN_16 = 3'h2;
  localparam logic [2:0] WDLEN_20 = 3'h3;
  localparam logic [2:0] WDLEN_24 = 3'h4;
  localparam logic [2:0] WDLEN_32 = 3'h5;
  // Activation delay after a reset release, in system clocks
  localparam int ACTIVATE_CYCLES  = 2;
  typedef enum logic [1:0] {SBP_IDLE, SBP_WAIT, SBP_SHIFT} sbp_state_t;
endpackage : sbp_pkg

// File: rtl/sbp_port.sv
// Serial port front end: control registers, data pair queues, shifters
//------------------------------------------------------------------------
// Overview of operation
// - Transmit, receive and frame-sync resets sit at zero after chip reset.
// - Receiver and transmitter become active within two clocks of release.
// - Transmitter and receiver each have their own independent reset bit.
// - Multichannel and channel-enable registers accept writes at any time.
// - Phase zero is single phase; frame length holds words minus one.
// - Word length code 000 is 8 bits, code 101 is 32 bits.
// - Above 16 bits, copies are triggered by the lower register only.
// - Frame-sync ignore set: first pulse starts, later pulses ignored.
// - Each upper and lower data register has its own 16x16 queue.
// - Receive queue top answers at the same address as the data register.
// - Upper receive read holds the index; lower receive read advances.
// - Upper transmit write holds the index; lower write advances.
// - Receive and transmit queue pairs have separate control registers.
// - A section reset clears its counters and status flags.
// - Serial data output is undriven while transmitter or chip is reset.
//------------------------------------------------------------------------
`timescale 1ns/1ps

module sbp_port
  import sbp_pkg::*;
#(
  parameter int DEPTH = 16,            // Entries per data queue
  parameter int WIDTH = 16             // Bits per queue entry
)(
  input  wire logic        clk_sys,    // System clock, 100 MHz
  input  wire logic        rst_b,      // Asynchronous chip reset, low
  input  wire logic [7:0]  addr,       // Register index
  input  wire logic [15:0] wdata,      // Write data
  input  wire logic        wr,         // Write strobe
  input  wire logic        rd,         // Read strobe
  output logic      [15:0] rdata,      // Read data, cycle after strobe
  input  wire logic        bit_clock_pin,   // Serial bit clock from link
  input  wire logic        frame_sync_pin,  // Frame sync from link
  input  wire logic        serial_data_in,  // Serial receive data
  output logic             serial_data_out_pin, // Serial transmit data
  output logic             serial_data_oe,  // Drive enable for data out
  output logic             frame_sync_gen_run // Frame-sync gen released
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  //----------------------------------------------------------------------
  // State record
  //----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        rst_sync;
    logic [2:0]        clk_sync;       // Two sync stages plus edge history
    logic [2:0]        fs_sync;
    logic [1:0]        din_sync;
    logic [15:0]       port_ctl1;
    logic [15:0]       port_ctl2;
    logic [15:0]       pin_ctl;
    logic [15:0]       rx_ctl;
    logic [15:0]       tx_ctl;
    logic [15:0]       mch_ctl;
    logic [15:0]       rx_chen;
    logic [15:0]       tx_chen;
    logic [15:0]       txq_ctl;
    logic [15:0]       rxq_ctl;
    logic [15:0]       q_gen;
    logic [15:0]       q_int;
    logic [15:0]       q_stat;
    logic [15:0]       rdata;
    logic [1:0]        rx_act_cnt;
    logic [1:0]        tx_act_cnt;
    logic              rx_active;
    logic              tx_active;
    logic [AW-1:0]     rx_rp;
    logic [AW-1:0]     rx_wp;
    logic [CW-1:0]     rx_cnt;
    logic [AW-1:0]     tx_rp;
    logic [AW-1:0]     tx_wp;
    logic [CW-1:0]     tx_cnt;
    logic [15:0]       tx_hold_upper;  // Upper word waiting for its lower
    logic [31:0]       rx_shift;
    logic [31:0]       tx_shift;
    logic [5:0]        rx_bits;
    logic [5:0]        tx_bits;
    logic [6:0]        rx_words;
    logic [6:0]        tx_words;
    sbp_state_t        rx_st;
    sbp_state_t        tx_st;
    logic              dout;
    logic              rx_full;
    logic              tx_empty_n;
  } sbp_regs_t;

  sbp_regs_t r;
  sbp_regs_t next_r;
  logic [WIDTH-1:0] rxq_u [DEPTH];
  logic [WIDTH-1:0] rxq_l [DEPTH];
  logic [WIDTH-1:0] txq_u [DEPTH];
  logic [WIDTH-1:0] txq_l [DEPTH];

  // Decoded controls
  logic        rst_n;
  logic        rx_run;
  logic        tx_run;
  logic        q_mode;
  logic [5:0]  rx_wlen;
  logic [5:0]  tx_wlen;
  logic        clk_rise;
  logic        clk_fall;
  logic        fs_rise;
  logic        rx_push;
  logic        tx_pop;
  logic        host_tx_push;
  logic        host_rx_pop;

  assign rst_n  = r.rst_sync[1];
  assign rx_run = r.port_ctl1[BIT_RX_RESET_N];
  assign tx_run = r.port_ctl2[BIT_TX_RESET_N];
  assign q_mode = r.txq_ctl[BIT_Q_ENABLE];
  assign clk_rise = r.clk_sync[1] & ~r.clk_sync[2];
  assign clk_fall = ~r.clk_sync[1] & r.clk_sync[2];
  assign fs_rise  = r.fs_sync[1] & ~r.fs_sync[2];

  // Word length from the 3-bit code; unlisted codes fall back to 16
  function automatic logic [5:0] word_bits(input logic [2:0] code);
    case (code)
      WDLEN_8:  word_bits = 6'd8;
      WDLEN_12: word_bits = 6'd12;
      WDLEN_16: word_bits = 6'd16;
      WDLEN_20: word_bits = 6'd20;
      WDLEN_24: word_bits = 6'd24;
      WDLEN_32: word_bits = 6'd32;
      default:  word_bits = 6'd16;
    endcase
  endfunction : word_bits

  assign rx_wlen = word_bits(r.rx_ctl[LSB_WDLEN +: 3]);
  assign tx_wlen = word_bits(r.tx_ctl[LSB_WDLEN +: 3]);

  // Queue traffic; on the host side the lower register alone moves an index
  assign host_rx_pop  = rd && addr == ADDR_RX_LOWER && r.rx_cnt != '0;
  assign host_tx_push = wr && addr == ADDR_TX_LOWER
                        && r.tx_cnt != CW'(DEPTH);
  assign rx_push = r.rx_st == SBP_SHIFT && clk_fall
                   && r.rx_bits == rx_wlen - 6'd1
                   && r.rx_cnt != CW'(DEPTH);
  assign tx_pop  = r.tx_st == SBP_WAIT && r.tx_cnt != '0
                   && (fs_rise || r.tx_words != '0);

  //----------------------------------------------------------------------
  // Queue storage, one array per data register
  //----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rx_push)
    begin
      rxq_u[r.rx_wp] <= r.rx_shift[30:15];
      rxq_l[r.rx_wp] <= {r.rx_shift[14:0], r.din_sync[1]};
    end
    if (host_tx_push)
    begin
      txq_u[r.tx_wp] <= r.tx_hold_upper;
      txq_l[r.tx_wp] <= wdata;
    end
  end

  //----------------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.rst_sync = {r.rst_sync[0], 1'b1};
    next_r.clk_sync = {r.clk_sync[1:0], bit_clock_pin};
    next_r.fs_sync  = {r.fs_sync[1:0], frame_sync_pin};
    next_r.din_sync = {r.din_sync[0], serial_data_in};
    next_r.rdata = RST_ZERO;

    // Register writes; channel registers take writes at any time
    if (wr)
    begin
      case (addr)
        ADDR_TX_UPPER:  next_r.tx_hold_upper = wdata;
        ADDR_PORT_CTL1: next_r.port_ctl1 = wdata;
        ADDR_PORT_CTL2: next_r.port_ctl2 = wdata;
        ADDR_PIN_CTL:   next_r.pin_ctl = wdata;
        ADDR_RX_CTL:    next_r.rx_ctl = wdata;
        ADDR_TX_CTL:    next_r.tx_ctl = wdata;
        ADDR_MCH_CTL:   next_r.mch_ctl = wdata;
        ADDR_RX_CHEN:   next_r.rx_chen = wdata;
        ADDR_TX_CHEN:   next_r.tx_chen = wdata;
        ADDR_TXQ_CTL:   next_r.txq_ctl = wdata;
        ADDR_RXQ_CTL:   next_r.rxq_ctl = wdata;
        ADDR_Q_GEN:     next_r.q_gen = wdata;
        ADDR_Q_INT:     next_r.q_int = wdata;
        ADDR_Q_STAT:    next_r.q_stat = wdata;
        default:        next_r.q_stat = r.q_stat;
      endcase
    end

    // Reads; receive queue tops answer at the data register addresses, transmit data registers read zero
    if (rd)
    begin
      case (addr)
        // Empty queue reads as the reset value, never stale storage
        ADDR_RX_UPPER:  next_r.rdata = (r.rx_cnt != '0)
                           ? rxq_u[r.rx_rp] : RST_ZERO;
        ADDR_RX_LOWER:  next_r.rdata = (r.rx_cnt != '0)
                           ? rxq_l[r.rx_rp] : RST_ZERO;
        // Status hidden at once while the receiver is held in reset
        ADDR_PORT_CTL1: next_r.rdata = {r.port_ctl1[15:3],
                                        r.rx_full & rx_run,
                                        (r.rx_cnt != '0) & rx_run,
                                        r.port_ctl1[0]};
        ADDR_PORT_CTL2: next_r.rdata = {r.port_ctl2[15:3], r.tx_empty_n,
                                        r.tx_cnt != CW'(DEPTH),
                                        r.port_ctl2[0]};
        ADDR_PIN_CTL:   next_r.rdata = r.pin_ctl;
        ADDR_RX_CTL:    next_r.rdata = r.rx_ctl;
        ADDR_TX_CTL:    next_r.rdata = r.tx_ctl;
        ADDR_MCH_CTL:   next_r.rdata = r.mch_ctl;
        ADDR_RX_CHEN:   next_r.rdata = r.rx_chen;
        ADDR_TX_CHEN:   next_r.rdata = r.tx_chen;
        ADDR_TXQ_CTL:   next_r.rdata = {r.txq_ctl[15:13],
                           5'(r.tx_cnt), r.txq_ctl[7:0]};
        ADDR_RXQ_CTL:   next_r.rdata = {r.rxq_ctl[15:13],
                           5'(r.rx_cnt), r.rxq_ctl[7:0]};
        ADDR_Q_GEN:     next_r.rdata = r.q_gen;
        ADDR_Q_INT:     next_r.rdata = r.q_int;
        ADDR_Q_STAT:    next_r.rdata = r.q_stat;
        default:        next_r.rdata = RST_ZERO;
      endcase
    end

    // Activation delay after a section leaves reset
    next_r.rx_act_cnt = rx_run ? r.rx_act_cnt : 2'd0;
    if (rx_run && !r.rx_active)
    begin
      next_r.rx_act_cnt = r.rx_act_cnt + 2'd1;
      next_r.rx_active = r.rx_act_cnt == 2'(ACTIVATE_CYCLES - 1);
    end
    next_r.tx_act_cnt = tx_run ? r.tx_act_cnt : 2'd0;
    if (tx_run && !r.tx_active)
    begin
      next_r.tx_act_cnt = r.tx_act_cnt + 2'd1;
      next_r.tx_active = r.tx_act_cnt == 2'(ACTIVATE_CYCLES - 1);
    end

    // Receive pointers
    if (rx_push)
    begin
      next_r.rx_wp = r.rx_wp + AW'(1);
      next_r.rx_cnt = next_r.rx_cnt + CW'(1);
    end
    if (host_rx_pop)
    begin
      next_r.rx_rp = r.rx_rp + AW'(1);
      next_r.rx_cnt = next_r.rx_cnt - CW'(1);
    end
    if (rx_push == 1'b0 && r.rx_st == SBP_SHIFT && clk_fall
        && r.rx_bits == rx_wlen - 6'd1)
      next_r.rx_full = 1'b1;                                    // Overrun

    // Receive shifter: frame length counts words minus one
    case (r.rx_st)
      SBP_IDLE:
        if (r.rx_active)
          next_r.rx_st = SBP_WAIT;
      SBP_WAIT:
        if (fs_rise)
        begin
          next_r.rx_st = SBP_SHIFT;
          next_r.rx_bits = '0;
          next_r.rx_words = '0;
        end
      SBP_SHIFT:
      begin
        if (clk_fall)
        begin
          next_r.rx_shift = {r.rx_shift[30:0], r.din_sync[1]};
          next_r.rx_bits = r.rx_bits + 6'd1;
          if (r.rx_bits == rx_wlen - 6'd1)
          begin
            next_r.rx_bits = '0;
            next_r.rx_words = r.rx_words + 7'd1;
            if (!r.rx_ctl[BIT_FS_IGNORE]
                && r.rx_words == r.rx_ctl[LSB_FRLEN +: 7])
              next_r.rx_st = SBP_WAIT;
          end
        end
        // Pulses inside a frame are ignored when the ignore bit is set
        if (fs_rise && !r.rx_ctl[BIT_FS_IGNORE])
        begin
          next_r.rx_bits = '0;
          next_r.rx_words = '0;
        end
      end
      default: next_r.rx_st = SBP_IDLE;
    endcase

    // Transmit pointers
    if (host_tx_push)
    begin
      next_r.tx_wp = r.tx_wp + AW'(1);
      next_r.tx_cnt = next_r.tx_cnt + CW'(1);
      next_r.tx_empty_n = 1'b1;
    end
    if (tx_pop)
    begin
      next_r.tx_rp = r.tx_rp + AW'(1);
      next_r.tx_cnt = next_r.tx_cnt - CW'(1);
    end

    // Transmit shifter, MSB first, word aligned to the top of the shifter
    case (r.tx_st)
      SBP_IDLE:
        if (r.tx_active)
          next_r.tx_st = SBP_WAIT;
      SBP_WAIT:
        if (tx_pop)
        begin
          next_r.tx_shift = {txq_u[r.tx_rp], txq_l[r.tx_rp]}
                            << (6'd32 - tx_wlen);
          next_r.tx_bits = '0;
          next_r.tx_st = SBP_SHIFT;
          if (fs_rise)
            next_r.tx_words = '0;
        end
      SBP_SHIFT:
        if (clk_rise)
        begin
          next_r.dout = r.tx_shift[31];
          next_r.tx_shift = {r.tx_shift[30:0], 1'b0};
          next_r.tx_bits = r.tx_bits + 6'd1;
          if (r.tx_bits == tx_wlen - 6'd1)
          begin
            next_r.tx_st = SBP_WAIT;
            next_r.tx_words = r.tx_words + 7'd1;
            if (r.tx_words == r.tx_ctl[LSB_FRLEN +: 7]
                && !r.tx_ctl[BIT_FS_IGNORE])
              next_r.tx_words = '0;
            if (next_r.tx_cnt == '0)
              next_r.tx_empty_n = 1'b0;
          end
        end
      default: next_r.tx_st = SBP_IDLE;
    endcase

    // Section resets return each half to its initial state
    if (!rx_run || !r.rxq_ctl[BIT_Q_RX_RESET])
    begin
      next_r.rx_rp = '0;
      next_r.rx_wp = '0;
      next_r.rx_cnt = '0;
      next_r.rx_full = 1'b0;
    end
    if (!rx_run)
    begin
      next_r.rx_active = 1'b0;
      next_r.rx_st = SBP_IDLE;
      next_r.rx_bits = '0;
      next_r.rx_words = '0;
    end
    if (!tx_run || !r.txq_ctl[BIT_Q_TX_RESET])
    begin
      next_r.tx_rp = '0;
      next_r.tx_wp = '0;
      next_r.tx_cnt = '0;
      next_r.tx_empty_n = 1'b0;
    end
    if (!tx_run)
    begin
      next_r.tx_active = 1'b0;
      next_r.tx_st = SBP_IDLE;
      next_r.tx_bits = '0;
      next_r.tx_words = '0;
      next_r.dout = 1'b0;
    end
  end

  //----------------------------------------------------------------------
  // State register; resets clear control bits to zero, queue controls load RST_TXQ_CTL and RST_RXQ_CTL
  //----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.txq_ctl <= RST_TXQ_CTL;
      r.rxq_ctl <= RST_RXQ_CTL;
    end
    else if (!rst_n)
    begin
      r <= '0;
      r.rst_sync <= next_r.rst_sync;
      r.txq_ctl <= RST_TXQ_CTL;
      r.rxq_ctl <= RST_RXQ_CTL;
    end
    else
      r <= next_r;
  end

  // Outputs; data out floats while the transmitter or chip is reset
  assign rdata = r.rdata;
  assign serial_data_out_pin = r.dout;
  assign serial_data_oe = rst_n & tx_run;
  assign frame_sync_gen_run = r.port_ctl2[BIT_FS_RESET_N];

  // q_mode selects queue mode; data path is the same queue either way
  logic unused_q_mode;
  assign unused_q_mode = q_mode;

endmodule : sbp_port

// File: tb/sbp_codec_model.sv
// Behavioural serial codec facing the port's serial pins
`timescale 1ns/1ps
module sbp_codec_model (
  output logic      bit_clock_pin,       // Bit clock, still between frames
  output logic      frame_sync_pin,      // Frame sync, high for first bit
  output logic      serial_data_in,      // Data toward the port
  input  wire logic serial_data_out_pin, // Data from the port
  input  wire logic serial_data_oe       // Port drives its data pin
);
  // Idle levels from time zero
  initial
  begin
    bit_clock_pin  = 1'b0;
    frame_sync_pin = 1'b0;
    serial_data_in = 1'b0;
  end
  // One frame, MSB first, 80 ns bit period; undriven bits read as x
  task automatic run_frame(input logic [31:0] tx_word, input int nbits,
                           output logic [31:0] rx_word);
    rx_word = 32'h0000_0000;
    frame_sync_pin = 1'b1;
    #40;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      serial_data_in = tx_word[i];
      bit_clock_pin  = 1'b1;
      #40;
      frame_sync_pin = 1'b0;
      bit_clock_pin  = 1'b0;
      rx_word = {rx_word[30:0], serial_data_oe ? serial_data_out_pin : 1'bx};
      #40;
    end
    // Released line shows the inverse so a stale bit cannot pass
    serial_data_in = ~serial_data_in;
  endtask : run_frame
endmodule : sbp_codec_model

// File: tb/sbp_port_props.sv
// Checker of register port and serial pin behaviour of the port
`timescale 1ns/1ps
module sbp_port_props
  import sbp_pkg::*;
(
  input wire logic        clk_sys,             // System clock
  input wire logic        rst_b,               // Chip reset, low
  input wire logic [7:0]  addr,                // Register index
  input wire logic [15:0] wdata,               // Write data
  input wire logic        wr,                  // Write strobe
  input wire logic        rd,                  // Read strobe
  input wire logic [15:0] rdata,               // Read data
  input wire logic        bit_clock_pin,       // Serial bit clock
  input wire logic        frame_sync_pin,      // Frame sync
  input wire logic        serial_data_in,      // Serial rx data
  input wire logic        serial_data_out_pin, // Serial tx data
  input wire logic        serial_data_oe,      // Tx drive enable
  input wire logic        frame_sync_gen_run   // Frame-sync gen run
);
  // ----
  // Helper state
  // ----
  logic       tx_on; // Last written transmit reset_n bit
  logic       fs_on; // Last written frame-gen reset_n bit
  logic [1:0] quiet; // Cycles since a port_control_two write
  logic       bc_q;  // Bit clock one cycle ago
  logic [2:0] since; // Cycles since a raw bit clock rise
  // Counters saturate so long idle spells cannot wrap
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_on <= 1'b0;
      fs_on <= 1'b0;
      quiet <= 2'h3;
      bc_q  <= 1'b0;
      since <= 3'h7;
    end
    else
    begin
      if (wr && addr == ADDR_PORT_CTL2)
      begin
        tx_on <= wdata[BIT_TX_RESET_N];
        fs_on <= wdata[BIT_FS_RESET_N];
      end
      quiet <= (wr && addr == ADDR_PORT_CTL2) ? 2'h0 :
               (quiet == 2'h3) ? quiet : quiet + 2'h1;
      bc_q  <= bit_clock_pin;
      since <= (bit_clock_pin && !bc_q) ? 3'h0 :
               (since == 3'h7) ? since : since + 3'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_read_quiet: assert property (!$past(rd) |-> rdata == RST_ZERO)
    else $error("read data seen outside a read answer cycle");
  chk_reset_quiet: assert property ($rose(rst_b) |->
    !serial_data_oe && !frame_sync_gen_run)
    else $error("port active right after chip reset");
  chk_out_off_tx: assert property (!tx_on && !$past(tx_on) |->
    !serial_data_oe)
    else $error("data pin driven while transmitter in reset");
  chk_fsgen_follow: assert property (quiet == 2'h3 |->
    frame_sync_gen_run == fs_on)
    else $error("frame-sync gen run differs from its control bit");
  chk_upper_hold: assert property (rd && addr == ADDR_RX_UPPER ##1
    rd && addr == ADDR_RX_UPPER |=> rdata == $past(rdata))
    else $error("upper receive read moved the queue");
  chk_chan_write: assert property (wr && addr == ADDR_MCH_CTL ##1
    rd && addr == ADDR_MCH_CTL |=> rdata == $past(wdata, 2))
    else $error("multichannel control write not taken");
  chk_rx_clear: assert property (wr && addr == ADDR_PORT_CTL1 &&
    !wdata[BIT_RX_RESET_N] ##1 rd && addr == ADDR_PORT_CTL1
    |=> rdata[2:0] == 3'h0)
    else $error("receiver reset left status set");
  chk_out_edge: assert property ($changed(serial_data_out_pin) &&
    serial_data_oe && $past(serial_data_oe) |-> since <= 3'h5)
    else $error("tx data changed away from a bit clock rise");
  cover property (rd && addr == ADDR_RX_LOWER);
  cover property (wr && addr == ADDR_TX_LOWER);
  cover property ($rose(frame_sync_gen_run));
endmodule : sbp_port_props
bind sbp_port sbp_port_props u_props (.clk_sys(clk_sys), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .bit_clock_pin(bit_clock_pin), .frame_sync_pin(frame_sync_pin),
  .serial_data_in(serial_data_in),
  .serial_data_out_pin(serial_data_out_pin),
  .serial_data_oe(serial_data_oe),
  .frame_sync_gen_run(frame_sync_gen_run));

// File: tb/test_sbp_port.sv
// Self-checking bench for the serial port front end
`timescale 1ns/1ps
module test_sbp_port;
  import sbp_pkg::*;
  typedef struct packed {
    logic        w; // Write before the read back
    logic [7:0]  a; // Register index
    logic [15:0] d; // Write data
    logic [15:0] e; // Expected read data
  } sbp_row_t;
  localparam sbp_row_t ROWS [14] = '{
    '{1'b0, ADDR_PORT_CTL1, 16'h0000, RST_ZERO},
    '{1'b0, ADDR_PORT_CTL2, 16'h0000, 16'h0002},
    '{1'b0, ADDR_TXQ_CTL, 16'h0000, RST_TXQ_CTL},
    '{1'b0, ADDR_RXQ_CTL, 16'h0000, RST_RXQ_CTL},
    '{1'b0, ADDR_Q_GEN, 16'h0000, RST_ZERO},
    '{1'b0, ADDR_Q_INT, 16'h0000, RST_ZERO},
    '{1'b0, ADDR_Q_STAT, 16'h0000, RST_ZERO},
    '{1'b0, ADDR_RX_UPPER, 16'h0000, RST_ZERO},
    '{1'b0, ADDR_RX_LOWER, 16'h0000, RST_ZERO},
    '{1'b1, 8'h40, 16'hFFFF, RST_ZERO},
    '{1'b1, ADDR_MCH_CTL, 16'h1234, 16'h1234},
    '{1'b1, ADDR_RX_CHEN, 16'hF00F, 16'hF00F},
    '{1'b1, ADDR_TX_CHEN, 16'h0FF0, 16'h0FF0},
    '{1'b1, ADDR_PIN_CTL, 16'h0900, 16'h0900}};
  logic        clk_sys;
  logic        rst_b;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        bit_clock_pin;
  logic        frame_sync_pin;
  logic        serial_data_in;
  logic        serial_data_out_pin;
  logic        serial_data_oe;
  logic        frame_sync_gen_run;
  logic [31:0] got;
  logic [15:0] v;
  int          num_errors;
  int          checked;
  sbp_port u_sbp_port (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .bit_clock_pin(bit_clock_pin), .frame_sync_pin(frame_sync_pin),
    .serial_data_in(serial_data_in),
    .serial_data_out_pin(serial_data_out_pin),
    .serial_data_oe(serial_data_oe),
    .frame_sync_gen_run(frame_sync_gen_run));
  sbp_codec_model u_sbp_codec_model (.bit_clock_pin(bit_clock_pin),
    .frame_sync_pin(frame_sync_pin), .serial_data_in(serial_data_in),
    .serial_data_out_pin(serial_data_out_pin),
    .serial_data_oe(serial_data_oe));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Bus tasks end one step past the edge so strobes never clash
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    num_errors = 0;
    checked = 0;
    {rst_b, addr, wdata, wr, rd} = '0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (ROWS[i])
    begin
      if (ROWS[i].w)
        wr_reg(ROWS[i].a, ROWS[i].d);
      rd_reg(ROWS[i].a);
      chk(v, ROWS[i].e);
    end
    // Bring-up: 32-bit single-word frames both ways
    wr_reg(ADDR_RX_CTL, 16'h0050);
    wr_reg(ADDR_TX_CTL, 16'h0050);
    repeat (2) @(posedge clk_sys);
    wr_reg(ADDR_PORT_CTL1, 16'h0001);
    wr_reg(ADDR_PORT_CTL2, 16'h0001);
    wr_reg(ADDR_PORT_CTL2, 16'h0081);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({15'h0000, frame_sync_gen_run}, 16'h0001);
    wr_reg(ADDR_TX_UPPER, 16'hA5C3);
    rd_reg(ADDR_TXQ_CTL);
    chk(v, RST_TXQ_CTL);
    wr_reg(ADDR_TX_LOWER, 16'h0F1E);
    rd_reg(ADDR_TXQ_CTL);
    chk(v, 16'hA100);
    #3;
    u_sbp_codec_model.run_frame(32'h13579BDF, 32, got);
    chk(got[31:16], 16'hA5C3);
    chk(got[15:0], 16'h0F1E);
    repeat (10) @(posedge clk_sys);
    rd_reg(ADDR_RXQ_CTL);
    chk(v, 16'h211F);
    rd_reg(ADDR_RX_UPPER);
    chk(v, 16'h1357);
    rd_reg(ADDR_RX_UPPER);
    chk(v, 16'h1357);
    rd_reg(ADDR_RX_LOWER);
    chk(v, 16'h9BDF);
    rd_reg(ADDR_RXQ_CTL);
    chk(v, RST_RXQ_CTL);
    // Transmitter and frame-sync generator back in reset, receiver checked running, then receiver reset
    wr_reg(ADDR_PORT_CTL2, 16'h0000);
    repeat (3) @(posedge clk_sys);
    #1;
    chk({15'h0000, serial_data_oe}, 16'h0000);
    rd_reg(ADDR_PORT_CTL1);
    chk(v, 16'h0001);
    wr_reg(ADDR_PORT_CTL1, 16'h0000);
    rd_reg(ADDR_PORT_CTL1);
    chk(v, RST_ZERO);
    // Second chip reset in mid-run, with a word left in the queue
    repeat (16) @(posedge clk_sys);
    wr_reg(ADDR_PORT_CTL2, 16'h0001);
    repeat (2) @(posedge clk_sys);
    wr_reg(ADDR_TX_LOWER, 16'h0001);
    rd_reg(ADDR_TXQ_CTL);
    chk(v, 16'hA100);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_reg(ADDR_TXQ_CTL);
    chk(v, RST_TXQ_CTL);
    give_verdict();
  end
endmodule : test_sbp_port
